// ===== inc/flash_fe_pkg.sv
// Constants shared by the serial flash front end, executor and memory.
// Assumes a 20-bit byte address into a byte-wide array.
`default_nettype none
package flash_fe_pkg;
   localparam int ARRAY_AW = 20;
   localparam int BUF_AW = 8;
   // Instruction codes
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_FREAD = 8'h0b;
   localparam logic [7:0] OP_SECT = 8'h20;
   localparam logic [7:0] OP_DREAD = 8'h3b;
   localparam logic [7:0] OP_CHIP0 = 8'h60;
   localparam logic [7:0] OP_CHIP1 = 8'hc7;
   localparam logic [7:0] OP_BLOCK = 8'hd8;
   localparam logic [7:0] ERASED = 8'hff;
   // Frame byte counts
   localparam logic [9:0] NB_STEP = 10'h001;
   localparam logic [9:0] NB_OPCODE = 10'h001;
   localparam logic [9:0] NB_WRSR = 10'h002;
   localparam logic [9:0] NB_ADDR_LAST = 10'h003;
   localparam logic [9:0] HDR_ADDR = 10'h004;
   localparam logic [9:0] HDR_FAST = 10'h005;
   localparam logic [9:0] NB_PAGE = 10'h100;
   localparam logic [9:0] NBYTE_MAX = 10'h3ff;
   // Job sizes in bytes and alignment masks
   localparam logic [20:0] PAGE_BYTES = 21'h000100;
   localparam logic [20:0] SECT_BYTES = 21'h001000;
   localparam logic [20:0] BLOCK_BYTES = 21'h010000;
   localparam logic [20:0] CHIP_BYTES = 21'h100000;
   localparam logic [19:0] SECT_MASK = 20'hff000;
   localparam logic [19:0] BLOCK_MASK = 20'hf0000;
   // Bit counting on the link
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_LAST_DUAL = 3'h6;
   localparam logic [2:0] STEP_SINGLE = 3'h1;
   localparam logic [2:0] STEP_DUAL = 3'h2;
   // Status byte layout
   localparam int ST_BUSY = 0;
   localparam int ST_BP_LO = 2;
   localparam int ST_BP_HI = 5;
   localparam int ST_SRP = 7;
   // Block protect decode
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_ALL = 3'h5;
   localparam logic [4:0] BLOCK_COUNT = 5'h10;
   typedef enum logic [1:0] {
      EX_IDLE = 2'b00,
      EX_FETCH = 2'b01,
      EX_STORE = 2'b10
   } exec_state_t;
endpackage : flash_fe_pkg
`default_nettype wire

// ===== rtl/flash_executor.sv
// Program and erase sequencer: walks the array one byte per two cycles.
// Assumes registered read data from both the array and the page buffer.
`timescale 1ns/1ps
`default_nettype none
module flash_executor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Job request
   input wire logic start,
   input wire logic erase,
   input wire logic [19:0] base,
   input wire logic [20:0] count,
   output logic busy,
   // Array port
   output logic [19:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // Page buffer port
   output logic [7:0] buf_addr,
   input wire logic [7:0] buf_rdata
);
   import flash_fe_pkg::*;
   typedef struct packed {
      exec_state_t st;
      logic erase;
      logic [19:0] base;
      logic [20:0] idx;
      logic [20:0] count;
   } exec_t;
   exec_t r;
   exec_t next_r;

   always_comb begin
      next_r = r;
      // Program wraps inside its page; erase runs linearly
      if (r.erase) begin
         mem_addr = r.base + r.idx[19:0];
      end else begin
         mem_addr = {r.base[19:8], 8'(r.base[7:0] + r.idx[7:0])};
      end
      buf_addr = mem_addr[7:0];
      mem_we = (r.st == EX_STORE);
      // Programming can only clear bits, never set them
      mem_wdata = r.erase ? ERASED : (mem_rdata & buf_rdata);
      busy = (r.st != EX_IDLE);
      case (r.st)
         EX_IDLE: begin
            if (start) begin
               next_r.st = EX_FETCH;
               next_r.erase = erase;
               next_r.base = base;
               next_r.count = count;
               next_r.idx = '0;
            end
         end
         EX_FETCH: begin
            next_r.st = EX_STORE;
         end
         EX_STORE: begin
            next_r.idx = r.idx + 21'h000001;
            next_r.st = (next_r.idx == r.count) ? EX_IDLE : EX_FETCH;
         end
         default: begin
            next_r.st = EX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : flash_executor
`default_nettype wire

// ===== rtl/flash_front_end.sv
// Serial NOR flash front end: SPI slave link, command commit,
// write protection and the 1 MiB array with its page buffer.
// Assumes link_clk is the SPI clock from the host and may stop
// between frames; chip select and write protect come from pins.
//
// Operation
// - Sample instruction, address and data bits on rising serial clock.
// - Change output data after each falling serial clock edge.
// - Work in clock mode 0 and mode 3; host uses one of them.
// - Chip select high deselects and floats both data outputs.
// - Only while selected accept instruction bytes and drive read data.
// - After power-up, ignore instructions until chip select falls from high.
// - Dual fast read sends two bits per clock, one per line.
// - Input line drives data only during dual fast read.
// - Array is 1 MiB: 16 blocks, 256 sectors, 4096 pages.
// - Each 4 KB sector spans an aligned range of twelve low bits.
// - Programming only turns ones into zeros; erase restores ones.
// - Erase exists per sector, per block or whole chip only.
// - One page program takes one to 256 data bytes.
// - Clock cycles count from falling edge to falling edge.
// - Mode 0 first cycle runs from select fall to first falling edge.
// - Write protect pin can block status register writes.
// - Protect bits with the pin guard part or all of the array; the code applies the protect bits whatever the pin level.
// - Interface works up to 100 MHz, dual reads included.
// - Protect bit set with pin low refuses block protect writes.
// - Protect code 0 none, 1..4 top 1/2/4/8 blocks, 5..7 all.
// - Write, program and erase need select to rise on a byte boundary.
`timescale 1ns/1ps
`default_nettype none
module flash_front_end (
   // System side
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Serial link
   input wire logic link_clk,
   input wire logic chip_select_n,
   input wire logic write_protect_n,
   input wire logic data_line_zero_i,
   output logic data_line_zero_o,
   output logic data_line_zero_oe,
   output logic data_line_one_o,
   output logic data_line_one_oe,
   // Status
   output logic [7:0] status_value,
   output logic busy
);
   import flash_fe_pkg::*;

   // Link state on rising clock; kept across frames for commit
   typedef struct packed {
      logic [2:0] bits;
      logic [9:0] nbyte;
      logic [7:0] shreg;
      logic [7:0] op;
      logic [23:0] addr;
      logic [19:0] ptr;
      logic [7:0] sr_byte;
      logic aligned;
      logic seq;
      logic load;
      logic load_stat;
      logic dual;
      logic [1:0] armed_s;
      logic [15:0] stat_s;
   } link_t;

   // Output shifter on falling clock
   typedef struct packed {
      logic [7:0] outsr;
      logic drive;
      logic dual;
   } shift_t;

   // System side state
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] wp_s;
      logic [2:0] seq_s;
      logic cs_hi;
      logic wp_lo;
      logic seen;
      logic armed;
      logic wel;
      logic status_reg_protect;
      logic [3:0] bp;
      logic start;
      logic erase;
      logic [19:0] base;
      logic [20:0] count;
   } sys_t;

   link_t lk;
   link_t next_lk;
   shift_t sh;
   shift_t next_sh;
   sys_t sy;
   sys_t next_sy;
   logic fresh;

   logic [2:0] bits_e;
   logic [9:0] nbyte_e;
   logic [9:0] hdr;
   logic [7:0] byte_in;
   logic [7:0] opc;
   logic [7:0] wcol;
   logic [7:0] stat_sync;
   logic [19:0] new_addr;
   logic [19:0] rd_addr;
   logic dual_data;
   logic done;
   logic is_read;
   logic link_ok;
   logic load_now;
   logic buf_we;

   logic [7:0] arr_rdata_a;
   logic [7:0] arr_rdata_b;
   logic [7:0] buf_rdata;
   logic [19:0] ex_addr;
   logic [7:0] ex_col;
   logic [7:0] ex_wdata;
   logic ex_we;
   logic ex_busy;
   logic commit;
   logic wr_ok;
   logic prot;
   logic [9:0] data_nb;

   // Top-down protection of 64 KB blocks
   function automatic logic is_protected(input logic [2:0] code, input logic [3:0] blk);
      logic [4:0] first;
      first = BLOCK_COUNT - (5'h01 << (code - 3'h1));
      if (code == BP_NONE) begin
         return 1'b0;
      end else if (code >= BP_ALL) begin
         return 1'b1;
      end else begin
         return {1'b0, blk} >= first;
      end
   endfunction : is_protected

   // Link: shifting and decode on the rising edge
   always_comb begin
      next_lk = lk;
      // First rising edge of a frame sees cleared counters
      bits_e = fresh ? 3'h0 : lk.bits;
      nbyte_e = fresh ? 10'h000 : lk.nbyte;
      byte_in = {lk.shreg[6:0], data_line_zero_i};
      opc = (nbyte_e == 10'h000) ? byte_in : lk.op;
      dual_data = (opc == OP_DREAD) && (nbyte_e >= HDR_FAST);
      done = (bits_e == (dual_data ? BIT_LAST_DUAL : BIT_LAST));
      hdr = (opc == OP_READ) ? HDR_ADDR : HDR_FAST;
      is_read = (opc == OP_READ) || (opc == OP_FREAD) || (opc == OP_DREAD);
      // Upper address bits beyond the array wrap
      new_addr = {lk.addr[11:0], byte_in};
      // Read address goes straight to the RAM on the last address edge
      rd_addr = (nbyte_e == NB_ADDR_LAST) ? new_addr : lk.ptr;
      wcol = 8'(lk.addr[7:0] + nbyte_e[7:0] - HDR_ADDR[7:0]);
      stat_sync = lk.stat_s[15:8];
      link_ok = lk.armed_s[1] && !stat_sync[ST_BUSY];
      load_now = done && link_ok && is_read && (nbyte_e >= hdr - NB_STEP);
      buf_we = done && link_ok && (opc == OP_PROG) && (nbyte_e >= HDR_ADDR);
      if (done) begin
         next_lk.bits = 3'h0;
      end else begin
         next_lk.bits = bits_e + (dual_data ? STEP_DUAL : STEP_SINGLE);
      end
      next_lk.shreg = byte_in;
      next_lk.aligned = done;
      next_lk.seq = fresh ? ~lk.seq : lk.seq;
      next_lk.load = load_now;
      next_lk.load_stat = done && lk.armed_s[1] && (opc == OP_RDSR);
      next_lk.dual = (opc == OP_DREAD);
      next_lk.armed_s = {lk.armed_s[0], sy.armed};
      next_lk.stat_s = {lk.stat_s[7:0], status_value};
      next_lk.nbyte = nbyte_e;
      if (done) begin
         if (nbyte_e != NBYTE_MAX) begin
            next_lk.nbyte = nbyte_e + NB_STEP;
         end
         if (nbyte_e == 10'h000) begin
            next_lk.op = byte_in;
         end
         if (nbyte_e == NB_OPCODE) begin
            next_lk.sr_byte = byte_in;
         end
         if (nbyte_e >= NB_OPCODE && nbyte_e <= NB_ADDR_LAST) begin
            next_lk.addr = {lk.addr[15:0], byte_in};
         end
      end
      // Prefetch keeps the next byte ready one byte ahead
      if (load_now) begin
         next_lk.ptr = rd_addr + 20'h00001;
      end else if (done && nbyte_e == NB_ADDR_LAST) begin
         next_lk.ptr = new_addr;
      end
      // Edges while deselected (mode switch) would clobber the uncommitted record
      if (chip_select_n) begin
         next_lk = lk;
      end
   end

   // Fresh marks a frame with no rising edge yet
   always_ff @(posedge link_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // Link: output shifting on the falling edge
   always_comb begin
      next_sh = sh;
      // Mode 3 opens on a falling edge; a stale load must not fire
      if ((lk.load || lk.load_stat) && !fresh) begin
         next_sh.outsr = lk.load_stat ? stat_sync : arr_rdata_b;
         next_sh.drive = 1'b1;
         next_sh.dual = lk.dual && !lk.load_stat;
      end else if (sh.dual) begin
         next_sh.outsr = {sh.outsr[5:0], 2'b00};
      end else begin
         next_sh.outsr = {sh.outsr[6:0], 1'b0};
      end
   end

   always_ff @(negedge link_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         sh <= '0;
      end else begin
         sh <= next_sh;
      end
   end

   assign data_line_one_o = sh.outsr[7];
   assign data_line_one_oe = sh.drive;
   assign data_line_zero_o = sh.outsr[6];
   assign data_line_zero_oe = sh.drive && sh.dual;

   // System side: commit a finished frame
   always_comb begin
      next_sy = sy;
      next_sy.start = 1'b0;
      next_sy.cs_s = {sy.cs_s[1:0], chip_select_n};
      next_sy.wp_s = {sy.wp_s[1:0], write_protect_n};
      next_sy.seq_s = {sy.seq_s[1:0], lk.seq};
      if (sy.cs_s[2] == sy.cs_s[1]) begin
         next_sy.cs_hi = sy.cs_s[2];
      end
      if (sy.wp_s[2] == sy.wp_s[1]) begin
         next_sy.wp_lo = !sy.wp_s[2];
      end
      // A high select after reset arms the next falling edge
      if (sy.cs_hi) begin
         next_sy.armed = 1'b1;
      end
      commit = !sy.cs_hi && sy.cs_s[2] && sy.cs_s[1]
         && (sy.seq_s[2] == sy.seq_s[1]) && (sy.seq_s[2] != sy.seen);
      wr_ok = lk.aligned && sy.wel;
      prot = is_protected(sy.bp[2:0], lk.addr[19:16]);
      data_nb = lk.nbyte - HDR_ADDR;
      if (commit) begin
         next_sy.seen = sy.seq_s[2];
      end
      // Frame record is stable once select is back high
      if (commit && sy.armed && !ex_busy) begin
         case (lk.op)
            OP_WREN: begin
               next_sy.wel = 1'b1;
            end
            OP_WRDI: begin
               next_sy.wel = 1'b0;
            end
            OP_WRSR: begin
               if (wr_ok && lk.nbyte >= NB_WRSR) begin
                  next_sy.wel = 1'b0;
                  // Locked while protect bit set and pin low
                  if (!(sy.status_reg_protect && sy.wp_lo)) begin
                     next_sy.status_reg_protect = lk.sr_byte[ST_SRP];
                     next_sy.bp = lk.sr_byte[ST_BP_HI:ST_BP_LO];
                  end
               end
            end
            OP_PROG: begin
               if (wr_ok && lk.nbyte > HDR_ADDR) begin
                  next_sy.wel = 1'b0;
                  next_sy.start = !prot;
                  next_sy.erase = 1'b0;
                  next_sy.base = lk.addr[19:0];
                  if (data_nb >= NB_PAGE) begin
                     next_sy.count = PAGE_BYTES;
                  end else begin
                     next_sy.count = 21'(data_nb);
                  end
               end
            end
            OP_SECT: begin
               if (wr_ok && lk.nbyte == HDR_ADDR) begin
                  next_sy.wel = 1'b0;
                  next_sy.start = !prot;
                  next_sy.erase = 1'b1;
                  next_sy.base = lk.addr[19:0] & SECT_MASK;
                  next_sy.count = SECT_BYTES;
               end
            end
            OP_BLOCK: begin
               if (wr_ok && lk.nbyte == HDR_ADDR) begin
                  next_sy.wel = 1'b0;
                  next_sy.start = !prot;
                  next_sy.erase = 1'b1;
                  next_sy.base = lk.addr[19:0] & BLOCK_MASK;
                  next_sy.count = BLOCK_BYTES;
               end
            end
            OP_CHIP0, OP_CHIP1: begin
               if (wr_ok && lk.nbyte == NB_OPCODE) begin
                  next_sy.wel = 1'b0;
                  // Any protected block vetoes the whole chip
                  next_sy.start = (sy.bp[2:0] == BP_NONE);
                  next_sy.erase = 1'b1;
                  next_sy.base = '0;
                  next_sy.count = CHIP_BYTES;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sy <= '0;
      end else begin
         sy <= next_sy;
      end
   end

   assign status_value = {sy.status_reg_protect, 1'b0, sy.bp, sy.wel, ex_busy};
   assign busy = ex_busy;

   // Array: system side writes, link side reads
   flash_ram #(.AW(ARRAY_AW)) array_mem (
      .clk_a(clk_sys),
      .we_a(ex_we),
      .addr_a(ex_addr),
      .wdata_a(ex_wdata),
      .rdata_a(arr_rdata_a),
      .clk_b(link_clk),
      .addr_b(rd_addr),
      .rdata_b(arr_rdata_b)
   );

   // Page buffer: link side writes, system side reads
   flash_ram #(.AW(BUF_AW)) page_buf (
      .clk_a(link_clk),
      .we_a(buf_we),
      .addr_a(wcol),
      .wdata_a(byte_in),
      .rdata_a(),
      .clk_b(clk_sys),
      .addr_b(ex_col),
      .rdata_b(buf_rdata)
   );

   flash_executor executor (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(sy.start),
      .erase(sy.erase),
      .base(sy.base),
      .count(sy.count),
      .busy(ex_busy),
      .mem_addr(ex_addr),
      .mem_we(ex_we),
      .mem_wdata(ex_wdata),
      .mem_rdata(arr_rdata_a),
      .buf_addr(ex_col),
      .buf_rdata(buf_rdata)
   );
endmodule : flash_front_end
`default_nettype wire

// ===== rtl/flash_ram.sv
// Byte-wide two-clock RAM: port A reads and writes, port B reads.
// Assumes only port A ever writes; both read data are registered.
`timescale 1ns/1ps
`default_nettype none
module flash_ram #(
   parameter int AW = 8
) (
   // Port A
   input wire logic clk_a,
   input wire logic we_a,
   input wire logic [AW-1:0] addr_a,
   input wire logic [7:0] wdata_a,
   output logic [7:0] rdata_a,
   // Port B
   input wire logic clk_b,
   input wire logic [AW-1:0] addr_b,
   output logic [7:0] rdata_b
);
   import flash_fe_pkg::*;
   logic [7:0] mem [0:(1<<AW)-1];

   // Start out erased so unwritten bytes read back as ones
   initial begin
      for (int i = 0; i < (1 << AW); i++) begin
         mem[i] = ERASED;
      end
   end

   always_ff @(posedge clk_a) begin
      if (we_a) begin
         mem[addr_a] <= wdata_a;
      end
      rdata_a <= mem[addr_a];
   end

   always_ff @(posedge clk_b) begin
      rdata_b <= mem[addr_b];
   end
endmodule : flash_ram
`default_nettype wire

// ===== testbench/flash_front_end_chk.sv
// Port checks for the flash front end, all in the clk_sys domain.
// Assumes chip select stays high for at least 60 ns between frames.
`timescale 1ns/1ps
`default_nettype none
module flash_front_end_chk
   import flash_fe_pkg::*;
(
   // System side
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Serial link
   input wire logic link_clk,
   input wire logic chip_select_n,
   input wire logic write_protect_n,
   input wire logic data_line_zero_o,
   input wire logic data_line_zero_oe,
   input wire logic data_line_one_o,
   input wire logic data_line_one_oe,
   // Status
   input wire logic [7:0] status_value,
   input wire logic busy
);
   logic [3:0] wp_low_cycles;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Pin low long enough to pass the three-flop synchroniser
   always_ff @(posedge clk_sys) begin
      if (sys_rst || write_protect_n) begin
         wp_low_cycles <= 4'h0;
      end else if (wp_low_cycles != 4'h8) begin
         wp_low_cycles <= wp_low_cycles + 4'h1;
      end
   end
   sequence pin_settled;
      chip_select_n ##1 chip_select_n;
   endsequence
   sequence quiet_header;
      !data_line_one_oe [*8];
   endsequence
   deselect_float_a: assert property (pin_settled |-> !data_line_one_oe && !data_line_zero_oe)
      else $error("data line driven while deselected");
   select_quiet_a: assert property ($fell(chip_select_n) |-> quiet_header)
      else $error("read data driven before the header");
   dual_pair_a: assert property (data_line_zero_oe |-> data_line_one_oe)
      else $error("shared line driven outside a read");
   out_hold_a: assert property (!chip_select_n && $past(!chip_select_n) && link_clk && $past(link_clk)
      |-> $stable(data_line_one_o) && $stable(data_line_zero_o))
      else $error("output moved while serial clock high");
   wel_commit_a: assert property ($rose(status_value[1]) |-> $past(chip_select_n, 3))
      else $error("write enable set inside a frame");
   busy_commit_a: assert property ($rose(busy) |-> $past(chip_select_n, 2) ##[0:2] !status_value[1])
      else $error("job started inside a frame or enable kept");
   busy_hold_a: assert property ($rose(busy) |-> busy [*2])
      else $error("job shorter than one byte");
   wp_refuse_a: assert property (wp_low_cycles == 4'h8 && $past(status_value[ST_SRP])
      |-> status_value[ST_SRP:ST_BP_LO] == $past(status_value[ST_SRP:ST_BP_LO]))
      else $error("protect bits changed while locked");
endmodule : flash_front_end_chk
bind flash_front_end flash_front_end_chk chk (.clk_sys, .sys_rst, .link_clk, .chip_select_n, .write_protect_n,
   .data_line_zero_o, .data_line_zero_oe, .data_line_one_o, .data_line_one_oe, .status_value, .busy);
`default_nettype wire

// ===== testbench/spi_host_model.sv
// Host model: SPI bus master in mode 0 or mode 3.
// Assumes the bench calls its tasks one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Link driven by the host
   output logic link_clk,
   output logic chip_select_n,
   output logic data_line_zero_i,
   // Lines driven by the device
   input wire logic data_line_zero_o,
   input wire logic data_line_zero_oe,
   input wire logic data_line_one_o,
   input wire logic data_line_one_oe
);
   logic drv = 1'b0;
   logic idle = 1'b0;
   // Device wins the shared line while it drives
   assign data_line_zero_i = data_line_zero_oe ? data_line_zero_o : drv;
   initial begin
      link_clk = 1'b0;
      chip_select_n = 1'b1;
   end
   task open_frame(input bit mode3);
      idle = mode3;
      link_clk = mode3;
      #20 chip_select_n = 1'b0;
      #16;
   endtask : open_frame
   // Change at the falling edge, sample at the rising one
   task xfer(input logic [7:0] tx, input int nbits, input bit dual, output logic [7:0] rx);
      rx = 8'hxx;
      for (int i = 7; i > 7 - nbits; i -= dual ? 2 : 1) begin
         link_clk = 1'b0;
         drv = dual ? ~drv : tx[i];
         #16;
         // Shared line must stay released during single-line reads
         rx[i] = (data_line_one_oe && (dual || !data_line_zero_oe)) ? data_line_one_o : 1'bx;
         if (dual) rx[i - 1] = data_line_zero_oe ? data_line_zero_i : 1'bx;
         link_clk = 1'b1;
         #16;
      end
   endtask : xfer
   // Released line toggles so stale data cannot pass
   task close_frame;
      link_clk = idle;
      #16 chip_select_n = 1'b1;
      drv = ~drv;
      #100;
   endtask : close_frame
endmodule : spi_host_model
`default_nettype wire

// ===== testbench/test_serial_flash_spi_front_end.sv
// Bench for the flash front end: frames through the host model.
// Assumes the array starts erased and status bits reset to zero.
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_spi_front_end;
   import flash_fe_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic write_protect_n = 1'b1;
   wire logic link_clk;
   wire logic chip_select_n;
   wire logic data_line_zero_i;
   logic data_line_zero_o;
   logic data_line_zero_oe;
   logic data_line_one_o;
   logic data_line_one_oe;
   logic [7:0] status_value;
   logic busy;
   int fail_count = 0;
   int tests_run = 0;
   bit mode3 = 1'b0;
   logic [7:0] rd [$];
   always #5 clk_sys = ~clk_sys;
   flash_front_end uut (.clk_sys, .sys_rst, .link_clk, .chip_select_n, .write_protect_n, .data_line_zero_i,
      .data_line_zero_o, .data_line_zero_oe, .data_line_one_o, .data_line_one_oe, .status_value, .busy);
   spi_host_model host (.link_clk, .chip_select_n, .data_line_zero_i, .data_line_zero_o, .data_line_zero_oe,
      .data_line_one_o, .data_line_one_oe);
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task conclude;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task frame(input logic [7:0] tx [$], input int nread, input bit dual = 1'b0, input int lastbits = 8);
      logic [7:0] r;
      rd.delete();
      host.open_frame(mode3);
      foreach (tx[k]) host.xfer(tx[k], (k == tx.size() - 1) ? lastbits : 8, 1'b0, r);
      repeat (nread) begin
         host.xfer(8'h00, 8, dual, r);
         rd.push_back(r);
      end
      host.close_frame();
   endtask : frame
   task wait_idle;
      int n;
      n = 0;
      repeat (10) @(negedge clk_sys);
      while (busy !== 1'b0 && n < 20000) begin
         @(negedge clk_sys);
         n++;
      end
      check("busy", {7'h00, busy}, 8'h00);
   endtask : wait_idle
   task rdsr(input logic [7:0] e);
      frame('{OP_RDSR}, 1);
      check("status read", rd[0], e);
      check("status port", status_value, e);
   endtask : rdsr
   // Write enable, then the command in its own frame
   task wr(input logic [7:0] tx [$]);
      frame('{OP_WREN}, 0);
      frame(tx, 0);
      wait_idle;
   endtask : wr
   task rd_chk(input logic [23:0] a, input logic [7:0] e [$]);
      frame('{OP_READ, a[23:16], a[15:8], a[7:0]}, e.size());
      foreach (e[k]) check("array byte", rd[k], e[k]);
   endtask : rd_chk
   initial begin
      #500_000;
      fail_count++;
      conclude;
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk_sys);
      rdsr(8'h00);
      rd_chk(24'h0ff0fe, '{ERASED});
      frame('{OP_WREN}, 0);
      rdsr(8'h02);
      wr('{OP_PROG, 8'h0f, 8'hf0, 8'hfe, 8'h35, 8'hc3, 8'h7e});
      wr('{OP_PROG, 8'h0f, 8'hef, 8'hff, 8'h11});
      rdsr(8'h00);
      rd_chk(24'h0ff0fe, '{8'h35, 8'hc3});
      rd_chk(24'h0ff000, '{8'h7e});
      wr('{OP_PROG, 8'h0f, 8'hf0, 8'hfe, 8'h0f});
      rd_chk(24'h0ff0fe, '{8'h05});
      mode3 = 1'b1;
      frame('{OP_DREAD, 8'h0f, 8'hf0, 8'hfe, 8'h00}, 2, 1'b1);
      check("dual byte", rd[0], 8'h05);
      check("dual byte", rd[1], 8'hc3);
      frame('{OP_FREAD, 8'h0f, 8'hf0, 8'hff, 8'h00}, 1);
      check("fast byte", rd[0], 8'hc3);
      // Status write cut one bit short: refused, enable kept
      frame('{OP_WREN}, 0);
      frame('{OP_WRSR, 8'h04, 8'h00}, 0, 1'b0, 7);
      rdsr(8'h02);
      wr('{OP_SECT, 8'h0f, 8'hf1, 8'h23});
      rd_chk(24'h0fefff, '{8'h11, ERASED});
      rd_chk(24'h0ff0fe, '{ERASED});
      wr('{OP_WRSR, 8'h04});
      rdsr(8'h04);
      wr('{OP_PROG, 8'h0f, 8'h00, 8'h00, 8'h00});
      wr('{OP_PROG, 8'h0e, 8'hff, 8'hff, 8'h00});
      rd_chk(24'h0effff, '{8'h00, ERASED});
      rdsr(8'h04);
      wr('{OP_WRSR, 8'h84});
      write_protect_n = 1'b0;
      wr('{OP_WRSR, 8'h80});
      rdsr(8'h84);
      write_protect_n = 1'b1;
      wr('{OP_WRSR, 8'h14});
      rdsr(8'h14);
      wr('{OP_PROG, 8'h00, 8'h00, 8'h00, 8'h00});
      wr('{OP_CHIP1});
      rd_chk(24'h0effff, '{8'h00});
      rd_chk(24'h000000, '{ERASED});
      wr('{OP_WRSR, 8'h00});
      rdsr(8'h00);
      conclude;
   end
endmodule : test_serial_flash_spi_front_end
`default_nettype wire
